// File: verilog/ldo_ctrl_pkg.sv
// Constants, register map and field layout for the four-regulator LDO control block.
// Assumes one 125 MHz clock, AXI4-Lite register access and OTP values presented as stable inputs.
//
// Function
// - Run-state enable 0 keeps the regulator off in run state.
// - Standby-state enable 0 keeps the regulator off in standby state.
// - Sequenced regulators get both enables set at power-up; others default to 0.
// - Enable 0 means disabled with output pull-down, regardless of switch mode.
// - Enable 1 with switch mode 0 runs the regulator normally.
// - Enable 1 with switch mode 1 runs it as a pass-through load switch.
// - Regulating versus switch choice comes only from the OTP bit.
// - Run-state output voltage comes from a 4-bit run voltage field.
// - Standby output voltage comes from a separate 4-bit standby field.
// - Both voltage fields load from the OTP default code at power up.
// - Codes 0 to 15 map to 1.5 through 5.0 volts in the listed order.
// - Second regulator may follow its enable pin and voltage-select pin in hardware mode.
// - In switch mode the enable bit opens or closes the switch.
// - Switch current limit applies only when its enable bit is 1.
// - Discharge path connects whenever a regulator is disabled, in either mode, except in the tie-bypass case below.
// - Tie-bypass bit with quick power-up-off state uses the weak pull-down instead.
package ldo_ctrl_pkg;

  // ==========================================================
  // Sizes
  localparam int unsigned NUM_REG    = 4;
  localparam int unsigned VCODE_W    = 4;
  localparam int unsigned HW_REG_IDX = 1;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_ENABLE  = 8'h00;
  localparam logic [7:0] ADDR_RUN_V   = 8'h04;
  localparam logic [7:0] ADDR_STBY_V  = 8'h08;
  localparam logic [7:0] ADDR_CONFIG  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_VOUT    = 8'h14;

  // ==========================================================
  // Field positions
  localparam int unsigned EN_RUN_LSB   = 0;
  localparam int unsigned EN_STBY_LSB  = 4;
  localparam int unsigned CFG_ILIM_LSB = 0;
  localparam int unsigned CFG_TBB_BIT  = 4;
  localparam int unsigned CFG_HW_BIT   = 5;
  localparam int unsigned ST_ON_LSB    = 0;
  localparam int unsigned ST_SW_LSB    = 4;
  localparam int unsigned ST_DIS_LSB   = 8;
  localparam int unsigned ST_TBB_LSB   = 12;
  localparam int unsigned ST_STBY_BIT  = 16;

  // ==========================================================
  // Reset values and bus answers
  localparam logic [31:0] RESET_ZERO  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Output voltage in millivolts per code
  localparam logic [12:0] VOLT_MV [16] = '{
    13'd1500, 13'd1600, 13'd1800, 13'd1850, 13'd2150, 13'd2500, 13'd2800, 13'd3000,
    13'd3100, 13'd3150, 13'd3200, 13'd3300, 13'd3350, 13'd1650, 13'd1700, 13'd5000};

  typedef enum logic [1:0] {MODE_OFF, MODE_REGULATE, MODE_SWITCH} ldo_mode_e;

endpackage : ldo_ctrl_pkg

// File: verilog/ldo_channel.sv
// One regulator channel: mode decision, voltage selection and pull-down choice.
// Assumes enable and voltage fields already chosen from registers or pins.
`timescale 1ns/1ns
`default_nettype none
module ldo_channel
  import ldo_ctrl_pkg::*;
(
  // Clock and reset
  input  wire  logic               ref_clk,
  input  wire  logic               nrst,
  // Selected control
  input  wire  logic               enable_sel,
  input  wire  logic [VCODE_W-1:0] vcode_sel,
  input  wire  logic               otp_switch_mode_select,
  input  wire  logic               switch_current_limit_enable,
  input  wire  logic               tie_bypass_feature_enable,
  input  wire  logic               quick_powerup_off_state,
  // Analog controls
  output logic                     regulate_on,
  output logic                     switch_closed,
  output logic                     current_limit_on,
  output logic                     discharge_on,
  output logic                     weak_pulldown_on,
  output logic [VCODE_W-1:0]       vout_code,
  output logic [12:0]              vout_mv
);

  // ==========================================================
  // Mode decode
  ldo_mode_e mode_w;
  wire       tbb_w;

  assign mode_w = !enable_sel ? MODE_OFF :
                  otp_switch_mode_select ? MODE_SWITCH :
                  MODE_REGULATE;
  assign tbb_w  = tie_bypass_feature_enable && quick_powerup_off_state;

  // ==========================================================
  // Registered outputs
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regulate_on      <= 1'b0;
      switch_closed    <= 1'b0;
      current_limit_on <= 1'b0;
      discharge_on     <= 1'b1;
      weak_pulldown_on <= 1'b0;
      vout_code        <= '0;
      vout_mv          <= '0;
    end
    else
    begin
      regulate_on      <= (mode_w == MODE_REGULATE);
      switch_closed    <= (mode_w == MODE_SWITCH);
      current_limit_on <= (mode_w == MODE_SWITCH) && switch_current_limit_enable;
      discharge_on     <= (mode_w == MODE_OFF) && !tbb_w;
      weak_pulldown_on <= (mode_w == MODE_OFF) && tbb_w;
      vout_code        <= vcode_sel;
      vout_mv          <= VOLT_MV[vcode_sel];
    end
  end

  a_off_pulldown: assert property (@(posedge ref_clk) disable iff (!nrst)
    !enable_sel |=> !regulate_on && !switch_closed && (discharge_on || weak_pulldown_on))
    else $error("disabled channel not pulled down");
  a_switch_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
    enable_sel && otp_switch_mode_select |=> switch_closed && !regulate_on)
    else $error("switch mode not taken");
  a_regulate_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
    enable_sel && !otp_switch_mode_select |=> regulate_on && !discharge_on)
    else $error("regulate mode not taken");
  a_ilim_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    current_limit_on |-> switch_closed && $past(switch_current_limit_enable))
    else $error("current limit outside switch mode");
  a_tbb_weak: assert property (@(posedge ref_clk) disable iff (!nrst)
    !enable_sel && tbb_w |=> weak_pulldown_on && !discharge_on)
    else $error("weak pull-down not used");
  a_code_volt: assert property (@(posedge ref_clk) disable iff (!nrst)
    vcode_sel == 4'hF |=> vout_mv == 13'd5000)
    else $error("code 15 not 5.0 V");

endmodule : ldo_channel
`default_nettype wire

// File: verilog/ldo_ctrl_top.sv
// Top of the LDO enable and mode control: AXI4-Lite registers, OTP load, state select.
// Assumes OTP inputs are valid while load_otp pulses and pins are synchronous.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ldo_ctrl_top
  import ldo_ctrl_pkg::*;
(
  // Clock and reset
  input  wire  logic                         ref_clk,
  input  wire  logic                         nrst,
  // AXI4-Lite write
  input  wire  logic [7:0]                   s_axi_awaddr,
  input  wire  logic                         s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire  logic [31:0]                  s_axi_wdata,
  input  wire  logic [3:0]                   s_axi_wstrb,
  input  wire  logic                         s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire  logic                         s_axi_bready,
  // AXI4-Lite read
  input  wire  logic [7:0]                   s_axi_araddr,
  input  wire  logic                         s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire  logic                         s_axi_rready,
  // System state and power-up
  input  wire  logic                         standby_state,
  input  wire  logic                         quick_powerup_off_state,
  input  wire  logic                         load_otp,
  input  wire  logic [NUM_REG-1:0]           otp_in_sequence,
  input  wire  logic [NUM_REG-1:0]           otp_switch_mode_select,
  input  wire  logic [NUM_REG*VCODE_W-1:0]   otp_default_voltage_code,
  // Hardware control pins for the second regulator
  input  wire  logic                         second_regulator_enable_pin,
  input  wire  logic                         voltage_select_pin,
  // Regulator controls
  output logic [NUM_REG-1:0]                 regulate_on,
  output logic [NUM_REG-1:0]                 switch_closed,
  output logic [NUM_REG-1:0]                 current_limit_on,
  output logic [NUM_REG-1:0]                 discharge_on,
  output logic [NUM_REG-1:0]                 weak_pulldown_on,
  output logic [NUM_REG*VCODE_W-1:0]         vout_code
);

  // ==========================================================
  // Registers
  logic [NUM_REG-1:0]         reg_run_state_enable;
  logic [NUM_REG-1:0]         reg_standby_state_enable;
  logic [NUM_REG*VCODE_W-1:0] run_state_voltage_code;
  logic [NUM_REG*VCODE_W-1:0] standby_state_voltage_code;
  logic [NUM_REG-1:0]         switch_current_limit_enable;
  logic                       tie_bypass_feature_enable;
  logic                       hw_control_reg;

  // ==========================================================
  // Bus slave: one write and one read; a read answered after one cycle, a write after two
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  wire         wr_go;
  wire         wr_hit;
  wire         rd_go;
  wire  [31:0] rd_word;
  wire         rd_hit;
  wire  [31:0] status_word;

  function automatic logic known_addr(input logic [7:0] a, input logic wr);
    known_addr = (a == ADDR_ENABLE) || (a == ADDR_RUN_V) || (a == ADDR_STBY_V) ||
                 (a == ADDR_CONFIG) || (!wr && ((a == ADDR_STATUS) || (a == ADDR_VOUT)));
  endfunction : known_addr

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go         = aw_held_reg && w_held_reg;
  assign wr_hit        = known_addr(awaddr_reg, 1'b1);
  assign rd_go         = s_axi_arvalid && s_axi_arready;
  assign rd_hit        = known_addr(s_axi_araddr, 1'b0);

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= RESET_ZERO;
      wstrb_reg    <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign status_word = {15'h0000, standby_state, weak_pulldown_on, discharge_on, switch_closed, regulate_on};
  assign rd_word = (s_axi_araddr == ADDR_ENABLE) ? {24'h000000, reg_standby_state_enable, reg_run_state_enable} :
                   (s_axi_araddr == ADDR_RUN_V)  ? {16'h0000, run_state_voltage_code} :
                   (s_axi_araddr == ADDR_STBY_V) ? {16'h0000, standby_state_voltage_code} :
                   (s_axi_araddr == ADDR_CONFIG) ? {26'h0000000, hw_control_reg, tie_bypass_feature_enable,
                                                    switch_current_limit_enable} :
                   (s_axi_araddr == ADDR_STATUS) ? status_word :
                   (s_axi_araddr == ADDR_VOUT)   ? {16'h0000, vout_code} : RESET_ZERO;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= RESET_ZERO;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // Register writes; the OTP load overrides software in the same cycle
  wire wr_en   = wr_go && wr_hit && (awaddr_reg == ADDR_ENABLE) && wstrb_reg[0];
  wire wr_runv = wr_go && wr_hit && (awaddr_reg == ADDR_RUN_V);
  wire wr_stbv = wr_go && wr_hit && (awaddr_reg == ADDR_STBY_V);
  wire wr_cfg  = wr_go && wr_hit && (awaddr_reg == ADDR_CONFIG) && wstrb_reg[0];

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      reg_run_state_enable        <= '0;
      reg_standby_state_enable    <= '0;
      run_state_voltage_code      <= '0;
      standby_state_voltage_code  <= '0;
      switch_current_limit_enable <= '0;
      tie_bypass_feature_enable   <= 1'b0;
      hw_control_reg              <= 1'b0;
    end
    else if (load_otp)
    begin
      reg_run_state_enable       <= otp_in_sequence;
      reg_standby_state_enable   <= otp_in_sequence;
      run_state_voltage_code     <= otp_default_voltage_code;
      standby_state_voltage_code <= otp_default_voltage_code;
    end
    else
    begin
      if (wr_en)
      begin
        reg_run_state_enable     <= wdata_reg[EN_RUN_LSB +: NUM_REG];
        reg_standby_state_enable <= wdata_reg[EN_STBY_LSB +: NUM_REG];
      end
      for (int b = 0; b < 2; b++)
      begin
        if (wr_runv && wstrb_reg[b])
          run_state_voltage_code[b*8 +: 8] <= wdata_reg[b*8 +: 8];
        if (wr_stbv && wstrb_reg[b])
          standby_state_voltage_code[b*8 +: 8] <= wdata_reg[b*8 +: 8];
      end
      if (wr_cfg)
      begin
        switch_current_limit_enable <= wdata_reg[CFG_ILIM_LSB +: NUM_REG];
        tie_bypass_feature_enable   <= wdata_reg[CFG_TBB_BIT];
        hw_control_reg              <= wdata_reg[CFG_HW_BIT];
      end
    end
  end

  // ==========================================================
  // Per-channel selection and channel logic
  logic [12:0] vout_mv_w [NUM_REG];

  for (genvar i = 0; i < NUM_REG; i++)
  begin : g_ch
    wire               sw_en_w  = standby_state ? reg_standby_state_enable[i]
                                                : reg_run_state_enable[i];
    wire [VCODE_W-1:0] sw_v_w   = standby_state ? standby_state_voltage_code[i*VCODE_W +: VCODE_W]
                                                : run_state_voltage_code[i*VCODE_W +: VCODE_W];
    wire               hw_w     = hw_control_reg && (i == HW_REG_IDX);
    // Pin picks between the run and standby codes: no extra code field needed
    wire [VCODE_W-1:0] pin_v_w  = voltage_select_pin ? standby_state_voltage_code[i*VCODE_W +: VCODE_W]
                                                     : run_state_voltage_code[i*VCODE_W +: VCODE_W];
    wire               en_w     = hw_w ? second_regulator_enable_pin : sw_en_w;
    wire [VCODE_W-1:0] v_w      = hw_w ? pin_v_w : sw_v_w;

    ldo_channel u_ch (
      .ref_clk                     (ref_clk),
      .nrst                        (nrst),
      .enable_sel                  (en_w),
      .vcode_sel                   (v_w),
      .otp_switch_mode_select      (otp_switch_mode_select[i]),
      .switch_current_limit_enable (switch_current_limit_enable[i]),
      .tie_bypass_feature_enable   (tie_bypass_feature_enable),
      .quick_powerup_off_state     (quick_powerup_off_state),
      .regulate_on                 (regulate_on[i]),
      .switch_closed               (switch_closed[i]),
      .current_limit_on            (current_limit_on[i]),
      .discharge_on                (discharge_on[i]),
      .weak_pulldown_on            (weak_pulldown_on[i]),
      .vout_code                   (vout_code[i*VCODE_W +: VCODE_W]),
      .vout_mv                     (vout_mv_w[i])
    );
  end

  // ==========================================================
  // Checks
  a_run_disable: assert property (@(posedge ref_clk) disable iff (!nrst)
    !standby_state && !hw_control_reg && !reg_run_state_enable[0] |=> !regulate_on[0] && !switch_closed[0])
    else $error("run-state disable ignored");
  a_stby_disable: assert property (@(posedge ref_clk) disable iff (!nrst)
    standby_state && !hw_control_reg && !reg_standby_state_enable[2] |=> !regulate_on[2] && !switch_closed[2])
    else $error("standby disable ignored");
  a_otp_load: assert property (@(posedge ref_clk) disable iff (!nrst)
    load_otp |=> run_state_voltage_code == $past(otp_default_voltage_code)
      && standby_state_voltage_code == $past(otp_default_voltage_code)
      && reg_run_state_enable == $past(otp_in_sequence))
    else $error("OTP defaults not loaded");
  a_stby_volt: assert property (@(posedge ref_clk) disable iff (!nrst)
    standby_state && !load_otp |=> vout_code[3:0] == $past(standby_state_voltage_code[3:0]))
    else $error("standby voltage not selected");
  a_pin_enable: assert property (@(posedge ref_clk) disable iff (!nrst)
    hw_control_reg && !second_regulator_enable_pin |=> !regulate_on[1] && !switch_closed[1])
    else $error("enable pin ignored");
  a_bus_answer: assert property (@(posedge ref_clk) disable iff (!nrst)
    rd_go |=> s_axi_rvalid)
    else $error("read not answered");
  a_volt_table: assert property (@(posedge ref_clk) disable iff (!nrst)
    vout_code[11:8] == 4'hD |-> vout_mv_w[2] == 13'h672)
    else $error("code 13 not 1.65 V");

  c_switch_on:  cover property (@(posedge ref_clk) disable iff (!nrst) switch_closed[0]);
  c_hw_control: cover property (@(posedge ref_clk) disable iff (!nrst) hw_control_reg && regulate_on[1]);
  c_tbb:        cover property (@(posedge ref_clk) disable iff (!nrst) weak_pulldown_on[3]);
  c_state_swap: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(standby_state) && regulate_on[0]);

endmodule : ldo_ctrl_top
`default_nettype wire

// File: dv/ldo_ctrl_top_tb.sv
// Bench for ldo_ctrl_top: AXI4-Lite register access and regulator control outputs.
// Assumes ldo_ctrl_pkg compiled first; one 125 MHz clock, bench drives all ports.
`timescale 1ns/1ns
`default_nettype none
module ldo_ctrl_top_tb
  import ldo_ctrl_pkg::*;
;
  // ==========================================================
  // Signals
  logic ref_clk = 1'b0, nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic standby_state = 1'b0, quick_powerup_off_state = 1'b0, load_otp = 1'b0;
  logic [3:0] otp_in_sequence = 4'h0, otp_switch_mode_select = 4'h0;
  logic [15:0] otp_default_voltage_code = 16'h0;
  logic second_regulator_enable_pin = 1'b0, voltage_select_pin = 1'b0;
  logic [3:0] regulate_on, switch_closed, current_limit_on, discharge_on, weak_pulldown_on;
  logic [15:0] vout_code;
  logic [31:0] rd;
  int n_mismatch = 0, checks_done = 0;

  always #4 ref_clk = ~ref_clk;

  ldo_ctrl_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .standby_state(standby_state),
    .quick_powerup_off_state(quick_powerup_off_state), .load_otp(load_otp),
    .otp_in_sequence(otp_in_sequence), .otp_switch_mode_select(otp_switch_mode_select),
    .otp_default_voltage_code(otp_default_voltage_code),
    .second_regulator_enable_pin(second_regulator_enable_pin),
    .voltage_select_pin(voltage_select_pin), .regulate_on(regulate_on),
    .switch_closed(switch_closed), .current_limit_on(current_limit_on),
    .discharge_on(discharge_on), .weak_pulldown_on(weak_pulldown_on), .vout_code(vout_code));

  // ==========================================================
  // Common tasks
  task automatic give_verdict;
    $display("Counts: checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Both tasks start and end right after a rising edge; handshakes judged pre-edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_hs, w_hs, done;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 1'b0;
    for (int i = 0; i < 50 && !done; i++)
    begin
      @(negedge ref_clk);
      aw_hs = s_axi_awvalid & s_axi_awready;
      w_hs = s_axi_wvalid & s_axi_wready;
      done = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge ref_clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
    end
    // One idle edge so the next call never re-raises bready in the same step
    @(posedge ref_clk);
    if (!done) begin n_mismatch++; give_verdict(); end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    logic ar_hs, done;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    for (int i = 0; i < 50 && !done; i++)
    begin
      @(negedge ref_clk);
      ar_hs = s_axi_arvalid & s_axi_arready;
      done = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge ref_clk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
    @(posedge ref_clk);
    if (!done) begin n_mismatch++; give_verdict(); end
  endtask : axi_read

  // Outputs are one register stage behind their cause
  task automatic settle;
    repeat (2) @(posedge ref_clk);
  endtask : settle

  task automatic outs(input logic [3:0] reg_on, input logic [3:0] sw, input logic [3:0] dis);
    check(32'(regulate_on), 32'(reg_on));
    check(32'(switch_closed), 32'(sw));
    check(32'(discharge_on), 32'(dis));
  endtask : outs

  // ==========================================================
  // Scenarios
  task automatic s_reset;
    outs(4'h0, 4'h0, 4'hF);
    axi_read(ADDR_ENABLE);
    check(rd, 32'h0);
  endtask : s_reset

  task automatic s_otp;
    otp_in_sequence <= 4'b0101;
    otp_switch_mode_select <= 4'b0100;
    otp_default_voltage_code <= 16'hFD0C;
    load_otp <= 1'b1;
    @(posedge ref_clk);
    load_otp <= 1'b0;
    settle();
    axi_read(ADDR_ENABLE);
    check(rd, 32'h55);
    axi_read(ADDR_RUN_V);
    check(rd, 32'hFD0C);
    axi_read(ADDR_STBY_V);
    check(rd, 32'hFD0C);
    outs(4'b0001, 4'b0100, 4'b1010);
    check(32'(vout_code), 32'hFD0C);
  endtask : s_otp

  task automatic s_state;
    axi_write(ADDR_STBY_V, 32'h1234);
    axi_write(ADDR_ENABLE, 32'hC3);
    settle();
    outs(4'b0011, 4'b0000, 4'b1100);
    standby_state <= 1'b1;
    settle();
    outs(4'b1000, 4'b0100, 4'b0011);
    check(32'(vout_code), 32'h1234);
    check(32'(switch_closed), 32'(otp_switch_mode_select));
  endtask : s_state

  task automatic s_cfg;
    axi_write(ADDR_CONFIG, 32'h0F);
    settle();
    check(32'(current_limit_on), 32'h4);
    axi_write(ADDR_CONFIG, 32'h10);
    quick_powerup_off_state <= 1'b1;
    settle();
    check(32'(current_limit_on), 32'h0);
    check(32'(weak_pulldown_on), 32'h3);
    check(32'(discharge_on), 32'h0);
    quick_powerup_off_state <= 1'b0;
    standby_state <= 1'b0;
    settle();
    check(32'(weak_pulldown_on), 32'h0);
  endtask : s_cfg

  task automatic s_hw;
    axi_write(ADDR_CONFIG, 32'h20);
    settle();
    check(32'(regulate_on), 32'h1);
    second_regulator_enable_pin <= 1'b1;
    settle();
    check(32'(regulate_on), 32'h3);
    check(32'(vout_code[7:4]), 32'h0);
    voltage_select_pin <= 1'b1;
    settle();
    check(32'(vout_code[7:4]), 32'h3);
  endtask : s_hw

  task automatic s_err;
    axi_read(8'h18);
    check(32'(resp), 32'(RESP_SLVERR));
    check(rd, 32'h0);
    axi_write(ADDR_STATUS, 32'hFFFF);
    check(32'(resp), 32'(RESP_SLVERR));
    axi_read(ADDR_ENABLE);
    check(32'(resp), 32'(RESP_OKAY));
    check(rd, 32'hC3);
  endtask : s_err

  initial
  begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    s_reset();
    s_otp();
    s_state();
    s_cfg();
    s_hw();
    s_err();
    give_verdict();
  end
endmodule : ldo_ctrl_top_tb
`default_nettype wire
